/* inc/sram_host_params.svh */
// timing figures, widths and reset values for the static ram host controller
`ifndef SRAM_HOST_PARAMS_SVH
`define SRAM_HOST_PARAMS_SVH

`define SRAM_ADDR_W 17
`define SRAM_DATA_W 8
`define SRAM_CNT_W 4

`define CLK_PERIOD_NS 50

// fastest grade figures, nanoseconds
`define READ_CYCLE_NS 10
`define ADDR_ACCESS_NS 10
`define SEL_ACCESS_NS 10
`define OE_ACCESS_NS 5
`define SEL_TO_FLOAT_NS 5
`define OUTPUT_HOLD_AFTER_ADDRESS_NS 4
`define WRITE_CYCLE_NS 10
`define ADDR_TO_WRITE_END_NS 7
`define SEL_TO_WRITE_END_NS 7
`define WRITE_PULSE_NS 7
`define DATA_SETUP_TO_WRITE_END_NS 5
`define STROBE_TO_FLOAT_NS 5

// least time rounded up to whole cycles, never below one
`define NS_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`define RD_WAIT_CYC `NS_UP(`SEL_ACCESS_NS > `READ_CYCLE_NS ? `SEL_ACCESS_NS : `READ_CYCLE_NS)
`define WR_PULSE_CYC `NS_UP(`WRITE_PULSE_NS > `ADDR_TO_WRITE_END_NS ? `WRITE_PULSE_NS : `ADDR_TO_WRITE_END_NS)
`define TURN_CYC `NS_UP(`SEL_TO_FLOAT_NS)

`define ADDR_RST 17'h0_0000
`define DATA_RST 8'h00
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1

`endif

/* inc/sram_host_pkg.sv */
// types shared by the static ram host controller
`include "sram_host_params.svh"
package sram_host_pkg;
  typedef logic [`SRAM_ADDR_W-1:0] sram_addr_t;
  typedef logic [`SRAM_DATA_W-1:0] sram_data_t;
  typedef logic [`SRAM_CNT_W-1:0] cyc_cnt_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ACCESS,
    ST_RD_HOLD,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_TURN
  } ctl_state_t;
endpackage

/* rtl/sram_cycle_timer.sv */
// down counter that stretches a pin phase over whole clock cycles
`timescale 1ns/1ns
`include "sram_host_params.svh"
module sram_cycle_timer (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire sram_host_pkg::cyc_cnt_t load_cycles,
  output logic done
);
  import sram_host_pkg::*;

  cyc_cnt_t cnt_ff;
  cyc_cnt_t nxt_cnt;

  always_comb begin
    if (load) begin
      nxt_cnt = load_cycles;
    end else if (cnt_ff != `CNT_ZERO) begin
      nxt_cnt = cnt_ff - `CNT_ONE;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= `CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // high in the last cycle of a phase of load_cycles cycles
  assign done = (cnt_ff == `CNT_ONE);
endmodule

/* rtl/sram_host_ctl.sv */
// clocked host controller for an asynchronous 128k x 8 static ram
// Operation
// (RULE1) memory holds 131072 bytes, 17-bit address, one shared 8-bit data bus
// (RULE2) memory has no clock or refresh; pins alone govern it
// (RULE3) write happens only while select and strobe are both low
// (RULE4) strobe stays high through every read
// (RULE5) chained reads keep select and output enable low, only address changes
// (RULE6) address is valid no later than select falls
// (RULE7) read data valid 10 ns after select, 5 ns after output enable
// (RULE8) memory holds old read data 4 ns after address change
// (RULE9) memory floats bus within 5 ns of select rising
// (RULE10) memory drives bus no sooner than 4 ns after select falls
// (RULE11) address held valid at least 7 ns before write end
// (RULE12) select low at least 7 ns before write end, whole period
// (RULE13) write data valid 5 ns before write end, held until closed
// (RULE14) memory floats bus within 5 ns of strobe falling
// (RULE15) memory drives bus no sooner than 3 ns after strobe rises
// (RULE16) with output enable low, pulse covers float delay plus data setup
// (RULE17) with output enable high, plain minimum pulse width suffices
// (RULE18) host never drives data while memory outputs are active
// (RULE19) select falling with or after strobe keeps memory outputs floating
// (RULE20) select low, enables high: bus floats; select high ignores the rest
// (RULE21) each access spans whole cycles meeting read, write and pulse minimums
`timescale 1ns/1ns
`include "sram_host_params.svh"
module sram_host_ctl (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire sram_host_pkg::sram_addr_t req_addr,
  input wire sram_host_pkg::sram_data_t req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output sram_host_pkg::sram_data_t rsp_rdata,
  output sram_host_pkg::sram_addr_t sram_addr,
  output logic sram_cs_b,
  output logic sram_oe_b,
  output logic sram_we_b,
  output sram_host_pkg::sram_data_t sram_dq_out,
  output logic sram_dq_oe,
  input wire sram_host_pkg::sram_data_t sram_dq_in
);
  import sram_host_pkg::*;

  ctl_state_t state_ff;
  ctl_state_t nxt_state;
  sram_addr_t addr_ff;
  sram_addr_t nxt_addr;
  sram_data_t dq_out_ff;
  sram_data_t nxt_dq_out;
  sram_data_t rdata_ff;
  sram_data_t nxt_rdata;
  logic cs_b_ff;
  logic nxt_cs_b;
  logic oe_b_ff;
  logic nxt_oe_b;
  logic we_b_ff;
  logic nxt_we_b;
  logic dq_oe_ff;
  logic nxt_dq_oe;
  logic ready_ff;
  logic nxt_ready;
  logic rsp_valid_ff;
  logic nxt_rsp_valid;
  logic tmr_load;
  cyc_cnt_t tmr_cycles;
  logic tmr_done;
  logic take;

  sram_cycle_timer u_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(tmr_load),
    .load_cycles(tmr_cycles),
    .done(tmr_done)
  );

  // a write offered while a read chain holds the bus waits for the turnaround
  assign take = req_valid && ready_ff && !(state_ff == ST_RD_HOLD && req_write);

  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_dq_out = dq_out_ff;
    nxt_rdata = rdata_ff;
    nxt_cs_b = cs_b_ff;
    nxt_oe_b = oe_b_ff;
    nxt_we_b = we_b_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_ready = ready_ff;
    nxt_rsp_valid = 1'b0;
    tmr_load = 1'b0;
    tmr_cycles = `CNT_ONE;
    unique case (state_ff)
      ST_IDLE: begin
        if (take) begin
          // address moves on the same edge as select falls
          nxt_addr = req_addr; // RULE6
          nxt_cs_b = 1'b0;
          nxt_we_b = 1'b1; // RULE4
          nxt_ready = 1'b0;
          if (req_write) begin
            // output enable kept high so the memory never fights our drivers
            nxt_oe_b = 1'b1; // RULE17
            nxt_dq_out = req_wdata;
            nxt_state = ST_WR_SETUP;
          end else begin
            nxt_oe_b = 1'b0; // RULE5
            tmr_load = 1'b1;
            tmr_cycles = cyc_cnt_t'(`RD_WAIT_CYC); // RULE21
            nxt_state = ST_RD_ACCESS;
          end
        end
      end
      ST_RD_ACCESS: begin
        if (tmr_done) begin
          nxt_rdata = sram_dq_in;
          nxt_rsp_valid = 1'b1;
          nxt_ready = 1'b1;
          nxt_state = ST_RD_HOLD;
        end
      end
      ST_RD_HOLD: begin
        if (take) begin
          // address-driven read: select and output enable stay low
          nxt_addr = req_addr; // RULE5
          nxt_ready = 1'b0;
          tmr_load = 1'b1;
          tmr_cycles = cyc_cnt_t'(`RD_WAIT_CYC); // RULE21
          nxt_state = ST_RD_ACCESS;
        end else begin
          nxt_cs_b = 1'b1;
          nxt_oe_b = 1'b1;
          nxt_ready = 1'b0;
          tmr_load = 1'b1;
          tmr_cycles = cyc_cnt_t'(`TURN_CYC);
          nxt_state = ST_TURN;
        end
      end
      ST_WR_SETUP: begin
        // data is applied only with the memory outputs known to be off
        nxt_we_b = 1'b0;
        nxt_dq_oe = 1'b1; // RULE18
        tmr_load = 1'b1;
        tmr_cycles = cyc_cnt_t'(`WR_PULSE_CYC); // RULE16
        nxt_state = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (tmr_done) begin
          // strobe rise closes the window; select, address and data stay
          nxt_we_b = 1'b1; // RULE11 RULE12
          nxt_state = ST_WR_END;
        end
      end
      ST_WR_END: begin
        // data released one cycle after the window closed
        nxt_dq_oe = 1'b0; // RULE13
        nxt_cs_b = 1'b1;
        nxt_ready = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_TURN: begin
        // memory may still drive for a float time after select rises
        if (tmr_done) begin
          nxt_ready = 1'b1; // RULE18
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cs_b = 1'b1;
        nxt_oe_b = 1'b1;
        nxt_we_b = 1'b1;
        nxt_dq_oe = 1'b0;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      addr_ff <= `ADDR_RST;
      dq_out_ff <= `DATA_RST;
      rdata_ff <= `DATA_RST;
      cs_b_ff <= 1'b1;
      oe_b_ff <= 1'b1;
      we_b_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
      ready_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      dq_out_ff <= nxt_dq_out;
      rdata_ff <= nxt_rdata;
      cs_b_ff <= nxt_cs_b;
      oe_b_ff <= nxt_oe_b;
      we_b_ff <= nxt_we_b;
      dq_oe_ff <= nxt_dq_oe;
      ready_ff <= nxt_ready;
      rsp_valid_ff <= nxt_rsp_valid;
    end
  end

  assign req_ready = ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rdata_ff;
  assign sram_addr = addr_ff;
  assign sram_cs_b = cs_b_ff;
  assign sram_oe_b = oe_b_ff;
  assign sram_we_b = we_b_ff;
  assign sram_dq_out = dq_out_ff;
  assign sram_dq_oe = dq_oe_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_read_we_high: assert property (!sram_oe_b |-> sram_we_b) // RULE4
    else $error("write strobe low during a read");
  chk_chain_keeps_sel: assert property ((state_ff == ST_RD_HOLD && take) |=> !sram_cs_b && !sram_oe_b) // RULE5
    else $error("read chain dropped select or output enable");
  // a chained read may move the address in the second cycle, but only with output enable still low
  chk_addr_with_sel: assert property ($fell(sram_cs_b) |=> $stable(sram_addr) ##1 ($stable(sram_addr) || !sram_oe_b)) // RULE6
    else $error("address moved right after select fell");
  chk_addr_in_write: assert property (!sram_we_b |-> $stable(sram_addr) && !sram_cs_b) // RULE11
    else $error("address not held through the write window");
  chk_sel_at_end: assert property ($rose(sram_we_b) |-> !sram_cs_b && !$past(sram_cs_b, 2)) // RULE12
    else $error("select not low before write end");
  chk_data_window: assert property ($fell(sram_we_b) |-> sram_dq_oe ##1 (sram_we_b && sram_dq_oe) ##1 !sram_dq_oe) // RULE13
    else $error("write data not held across the window");
  chk_no_fight: assert property (sram_dq_oe |-> sram_oe_b) // RULE18
    else $error("host drives data while output enable low");
  chk_pulse_len: assert property ($fell(sram_we_b) |=> $rose(sram_we_b)) // RULE16
    else $error("write pulse not one cycle");
  chk_turn_gap: assert property ($rose(sram_oe_b) |-> !sram_dq_oe [*3]) // RULE18
    else $error("drive began before the memory floated");
  chk_read_answer: assert property ($fell(sram_oe_b) |=> rsp_valid && !sram_cs_b) // RULE21
    else $error("read answer not after one access cycle");
endmodule

/* verification/sram_model.sv */
// behavioural static ram that answers the host controller's pins
`timescale 1ns/1ns
module sram_model (
  input wire sram_host_pkg::sram_addr_t addr,
  input wire logic cs_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire sram_host_pkg::sram_data_t dq_i,
  output sram_host_pkg::sram_data_t dq_q,
  output logic dq_en
);
  import sram_host_pkg::*;
  // sparse store, whole 17-bit space reachable
  sram_data_t mem [sram_addr_t];
  logic rd_on;
  // no clock here: pin levels and edges alone drive the model
  assign rd_on = !cs_b && !oe_b && we_b;
  // slowest legal turn-off, earliest legal turn-on
  assign #(4, 5) dq_en = rd_on;
  always @(addr or rd_on) begin
    // old byte stays 4 ns, then garbage until the access time runs out
    dq_q <= #4 ~dq_q;
    dq_q <= #10 mem.exists(addr) ? mem[addr] : ~dq_q;
  end
  // byte lands at the end of the select and strobe overlap
  always @(posedge we_b or posedge cs_b) begin
    if (!cs_b || !we_b)
      mem[addr] = dq_i;
  end
endmodule

/* verification/tb_top.sv */
// self-checking bench for the static ram host controller
`timescale 1ns/1ns
module tb_top;
  import sram_host_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  sram_addr_t req_addr = 17'h0_0000;
  sram_data_t req_wdata = 8'h00;
  sram_addr_t sram_addr;
  sram_data_t rsp_rdata, sram_dq_out, sram_dq_in, mem_q;
  sram_data_t bus_last = 8'h00;
  logic req_ready, rsp_valid, sram_cs_b, sram_oe_b, sram_we_b, sram_dq_oe, mem_en;
  logic [16:0] exp_v;
  // address and byte of the write last taken, for the pin checks during its strobe
  sram_addr_t wr_addr = 17'h0_0000;
  sram_data_t wr_data = 8'h00;
  logic [31:0] seed = 32'h2B85;
  int errors = 0;
  int checked = 0;
  sram_data_t shadow [sram_addr_t];
  sram_data_t expq [$];
  always #25 sys_clk = ~sys_clk;
  sram_host_ctl sram_host_ctl_inst (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sram_addr(sram_addr), .sram_cs_b(sram_cs_b),
    .sram_oe_b(sram_oe_b), .sram_we_b(sram_we_b), .sram_dq_out(sram_dq_out),
    .sram_dq_oe(sram_dq_oe), .sram_dq_in(sram_dq_in));
  sram_model sram_model_inst (.addr(sram_addr), .cs_b(sram_cs_b), .oe_b(sram_oe_b),
    .we_b(sram_we_b), .dq_i(sram_dq_in), .dq_q(mem_q), .dq_en(mem_en));
  // no pull on the data bus: a released bus flips every cycle
  assign sram_dq_in = sram_dq_oe ? sram_dq_out : (mem_en ? mem_q : ~bus_last);
  always @(posedge sys_clk) bus_last <= sram_dq_in;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // offer a request from a falling edge; n counts edges until taken
  task automatic req(input logic w, input sram_addr_t a, input sram_data_t d, output int n);
    logic rdy, tk;
    tk = 1'b0;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (!tk && n < 20) begin
      rdy = req_ready;
      @(negedge sys_clk);
      n++;
      // a write refused in read-hold leaves select high after the edge
      tk = rdy === 1'b1 && (!w || (sram_cs_b === 1'b0 && sram_oe_b === 1'b1));
    end
    cmp(tk, 1'b1);
    if (!tk) begin
      wrap_up();
    end else if (w) begin
      shadow[a] = d;
      wr_addr = a;
      wr_data = d;
    end else begin
      expq.push_back(shadow[a]);
    end
  endtask
  task automatic idle;
    req_valid = 1'b0;
    @(negedge sys_clk);
  endtask
  always @(negedge sys_clk) begin
    if (rst_b === 1'b1) begin
      if (rsp_valid === 1'b1) begin
        exp_v = 'x;
        if (expq.size() > 0)
          exp_v = {9'h000, expq.pop_front()};
        cmp(rsp_rdata, exp_v);
      end
      if (sram_oe_b === 1'b0)
        cmp(sram_we_b, 1'b1);
      if (sram_dq_oe === 1'b1)
        cmp({sram_cs_b, sram_oe_b, mem_en}, 3'h2);
      if (sram_we_b === 1'b0)
        cmp({sram_cs_b, sram_dq_oe, sram_addr === wr_addr, sram_dq_out === wr_data}, 4'h7);
    end
  end
  initial begin
    int n;
    logic w;
    sram_addr_t a;
    repeat (8) @(negedge sys_clk);
    cmp({sram_cs_b, sram_oe_b, sram_we_b, sram_dq_oe, req_ready, rsp_valid}, 6'h3A);
    rst_b = 1'b1;
    req(1'b1, 17'h0_0000, 8'h3C, n);
    cmp(n, 1);
    req(1'b1, 17'h1_FFFF, 8'hC3, n);
    cmp(n, 4);
    req(1'b0, 17'h0_0000, 8'h00, n);
    cmp(n, 4);
    req(1'b0, 17'h1_FFFF, 8'h00, n);
    cmp(n, 2);
    req(1'b1, 17'h0_0001, 8'h5A, n);
    cmp(n, 4);
    req(1'b0, 17'h0_0001, 8'h00, n);
    cmp(n, 4);
    idle();
    $display("test directed done");
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      a = {seed[19:16], 10'h155, seed[2:0]};
      w = seed[8] || !shadow.exists(a);
      req(w, a, seed[31:24], n);
      if (seed[9])
        idle();
    end
    idle();
    repeat (6) @(negedge sys_clk);
    cmp(expq.size(), 0);
    $display("test random done");
    rst_b = 1'b0;
    @(negedge sys_clk);
    cmp({sram_cs_b, sram_oe_b, sram_we_b, sram_dq_oe, req_ready, rsp_valid}, 6'h3A);
    rst_b = 1'b1;
    req(1'b0, 17'h1_FFFF, 8'h00, n);
    idle();
    repeat (4) @(negedge sys_clk);
    $display("test reset done");
    wrap_up();
  end
endmodule
